/* programmable_crc_generator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crc_gen_params.svh"
module programmable_crc_generator #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // chip power state
    input  wire logic                  idle_mode,
    // register port
    input  wire crc_gen_pkg::bus_addr_t addr,
    input  wire crc_gen_pkg::bus_data_t wdata,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output var  crc_gen_pkg::bus_data_t rdata,
    // interrupt
    output var  logic                  irq
);
    import crc_gen_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic          enable;
    logic          stop_idle;
    logic          isel;
    logic          go;
    logic          lsb_first;
    logic [4:0]    word_width_field;
    logic [4:0]    poly_length_field;
    logic [31:1]   taps;
    logic [31:0]   result_register;
    logic [31:0]   shift_word;
    logic [4:0]    bit_cnt;
    engine_state_t state;
    engine_state_t next_state;
    logic          irq_status;
    logic          irq_mask;
    logic          sel_ctrl1;
    logic          sel_ctrl2;
    logic          sel_taph;
    logic          sel_tapl;
    logic          sel_data;
    logic          sel_result;
    logic          sel_status;
    logic          sel_mask;
    logic          run;
    logic          last_bit;
    logic          crc_step;
    logic          start_word;
    logic          shift_done;
    logic          empty_event;
    logic          crc_event;
    logic          in_bit;
    logic          fb;
    logic [31:0]   len_mask;
    logic [31:0]   width_mask;
    logic [31:0]   tap_vec;
    logic [31:0]   next_crc;
    logic [31:0]   next_shift;
    logic [31:0]   ctrl1_view;
    logic [31:0]   read_mux;
    logic          next_status;

    crc_fifo_if #(.WIDTH(32), .CW(5)) fifo_bus ();

    crc_word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
        .mclk (mclk),
        .rst_n(rst_n),
        .port (fifo_bus.store)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign sel_ctrl1  = (addr == `OFS_CTRL_ONE);
    assign sel_ctrl2  = (addr == `OFS_CTRL_TWO);
    assign sel_taph   = (addr == `OFS_TAP_HIGH);
    assign sel_tapl   = (addr == `OFS_TAP_LOW);
    assign sel_data   = (addr == `OFS_DATA_IN);
    assign sel_result = (addr == `OFS_RESULT);
    assign sel_status = (addr == `OFS_IRQ_STATUS);
    assign sel_mask   = (addr == `OFS_IRQ_MASK);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // writable control bits, unimplemented bits dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable    <= 1'b0;
            stop_idle <= 1'b0;
            isel      <= 1'b0;
            go        <= 1'b0;
            lsb_first <= 1'b0;
        end else if (wr_en && sel_ctrl1) begin
            enable    <= wdata[`BIT_ENABLE];
            stop_idle <= wdata[`BIT_STOP_IDLE];
            isel      <= wdata[`BIT_ISEL];
            go        <= wdata[`BIT_GO];
            lsb_first <= wdata[`BIT_LSB_FIRST];
        end
    end

    // lengths and taps survive a cleared enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_width_field  <= `FIELD_RST;
            poly_length_field <= `FIELD_RST;
            taps              <= `TAP_RST;
        end else begin
            if (wr_en && sel_ctrl2) begin
                word_width_field  <= wdata[`FLD_WIDTH_LSB +: 5];
                poly_length_field <= wdata[`FLD_LEN_LSB +: 5];
            end
            if (wr_en && sel_taph) taps[31:16] <= wdata[15:0];
            if (wr_en && sel_tapl) taps[15:1] <= wdata[15:1];
        end
    end

    // ----------------------------------------------------------------
    // fifo hookup
    // ----------------------------------------------------------------
    // depth halves for long polynomials
    assign fifo_bus.cap = (poly_length_field > `LEN_SHALLOW_MAX) ?
                          `FIFO_SHALLOW : `FIFO_DEEP;
    assign width_mask          = 32'hFFFFFFFF >> (5'd31 - word_width_field);
    assign fifo_bus.push       = wr_en & sel_data & enable;
    assign fifo_bus.push_data  = wdata & width_mask;
    assign fifo_bus.pop        = start_word;
    assign fifo_bus.clear      = ~enable;

    // ----------------------------------------------------------------
    // shift engine datapath
    // ----------------------------------------------------------------
    // suspend while idle when asked to
    assign run        = enable & ~(stop_idle & idle_mode);
    assign last_bit   = (state == ST_SHIFT) && (bit_cnt == 5'h00);
    assign crc_step   = run & go & (state == ST_SHIFT);
    assign start_word = run & go & ~fifo_bus.empty
                        & ((state == ST_IDLE) | last_bit);
    // bit order selection
    assign in_bit     = lsb_first ? shift_word[0]
                                  : shift_word[word_width_field];
    assign next_shift = lsb_first ? {1'b0, shift_word[31:1]}
                                  : {shift_word[30:0], 1'b0};
    // top stage feeds back, so the top term is implied
    assign fb         = in_bit ^ result_register[poly_length_field];
    assign len_mask   = 32'hFFFFFFFF >> (5'd31 - poly_length_field);
    assign tap_vec    = {taps, 1'b1};
    // each set tap xors feedback into its stage
    assign next_crc   = ({result_register[30:0], 1'b0}
                        ^ ({32{fb}} & tap_vec)) & len_mask;

    // engine sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_word) next_state = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (!go) next_state = ST_IDLE;
                else if (crc_step && last_bit && !start_word)
                    next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state held in reset while disabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) state <= ST_IDLE;
        else if (!enable) state <= ST_IDLE;
        else state <= next_state;
    end

    // word load and bit countdown
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_word <= `WORD_RST;
            bit_cnt    <= `FIELD_RST;
        end else if (!enable) begin
            shift_word <= `WORD_RST;
            bit_cnt    <= `FIELD_RST;
        end else if (start_word) begin
            shift_word <= fifo_bus.pop_data;
            bit_cnt    <= word_width_field;
        end else if (crc_step) begin
            shift_word <= next_shift;
            bit_cnt    <= bit_cnt - 5'd1;
        end
    end

    // running remainder; software may seed it while idle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) result_register <= `WORD_RST;
        else if (!enable) result_register <= `WORD_RST;
        else if (crc_step) result_register <= next_crc;
        else if (wr_en && sel_result && state == ST_IDLE)
            result_register <= wdata & len_mask;
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    // source chosen by select bit
    assign shift_done  = crc_step & last_bit & fifo_bus.empty
                         & ~fifo_bus.push;
    assign empty_event = start_word & (fifo_bus.count == 5'h01)
                         & ~fifo_bus.push;
    assign crc_event   = isel ? empty_event : shift_done;
    // set wins over a write-one clear
    assign next_status = (irq_status & ~(wr_en & sel_status & wdata[0]))
                         | crc_event;

    // sticky status, mask and level output
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 1'b0;
            irq_mask   <= 1'b0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_status;
            if (wr_en && sel_mask) irq_mask <= wdata[0];
            irq        <= irq_status & irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    // live count and flags, zeros elsewhere
    assign ctrl1_view = {16'h0000, enable, 1'b0, stop_idle, fifo_bus.count,
                         fifo_bus.full, fifo_bus.empty, isel, go,
                         lsb_first, 3'h0};
    assign read_mux =
        sel_ctrl1  ? ctrl1_view :
        sel_ctrl2  ? {19'h00000, word_width_field, 3'h0, poly_length_field} :
        sel_taph   ? {16'h0000, taps[31:16]} :
        sel_tapl   ? {16'h0000, taps[15:1], 1'b0} :
        sel_result ? result_register :
        sel_status ? {31'h00000000, irq_status} :
        sel_mask   ? {31'h00000000, irq_mask} : 32'h00000000;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rdata <= 32'h00000000;
        else rdata <= rd_en ? read_mux : 32'h00000000;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_LEN_MASK: assert property (crc_step |=>
        ((result_register & ~$past(len_mask)) == 32'h00000000))
        else $error("remainder wider than polynomial");
    AST_WORD_BITS: assert property (start_word |=>
        (bit_cnt == $past(word_width_field)))
        else $error("word length not taken from width field");
    AST_X0_TERM: assert property (crc_step |=>
        (result_register[0] == $past(fb)))
        else $error("zero-order stage missed feedback");
    AST_DISABLE_CLEAR: assert property (!enable |=>
        (state == ST_IDLE && result_register == 32'h0
         && fifo_bus.count == 5'h00))
        else $error("disabled block not held in reset");
    AST_IDLE_FREEZE: assert property (
        (enable && stop_idle && idle_mode) |=>
        ($stable(bit_cnt) && $stable(shift_word)))
        else $error("engine moved while suspended");
    AST_EMPTY_RESET: assert property ($fell(enable) |=>
        (fifo_bus.empty && !fifo_bus.full))
        else $error("flags wrong after disable");
    AST_IRQ_PATH: assert property (
        (enable && isel && empty_event && irq_mask && !sel_mask)
        |=> irq_status ##1 irq)
        else $error("fifo-empty interrupt missing");
    AST_GO_OFF: assert property ((enable && !go) |=>
        (state == ST_IDLE))
        else $error("shifter running with start bit clear");
    AST_LSB_ORDER: assert property (
        (start_word && lsb_first && !wr_en) ##1 crc_step
        |-> (in_bit == $past(fifo_bus.pop_data[0])))
        else $error("first bit not lsb");
    AST_RESULT_STILL: assert property (
        (enable && state == ST_IDLE && !(wr_en && sel_result))
        |=> $stable(result_register))
        else $error("remainder moved while engine idle");
    AST_PUSH_COUNT: assert property (
        (enable && fifo_bus.push && !fifo_bus.full && !fifo_bus.pop)
        |=> (fifo_bus.count == $past(fifo_bus.count) + 5'h01))
        else $error("accepted push not counted");

    COV_WORD_START: cover property (start_word);
    COV_SHIFT_DONE: cover property (shift_done ##[1:4] irq);
    COV_EMPTY_EVENT: cover property (empty_event && isel);
    COV_MSB_STEP: cover property (crc_step && !lsb_first);
    COV_SUSPENDED: cover property (enable && stop_idle && idle_mode && go);
endmodule
`default_nettype wire

/* crc_gen_params.svh */
`ifndef CRC_GEN_PARAMS_SVH
`define CRC_GEN_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL_ONE     8'h00
`define OFS_CTRL_TWO     8'h04
`define OFS_TAP_HIGH     8'h08
`define OFS_TAP_LOW      8'h0C
`define OFS_DATA_IN      8'h10
`define OFS_RESULT       8'h14
`define OFS_IRQ_STATUS   8'h18
`define OFS_IRQ_MASK     8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_ENABLE       15
`define BIT_STOP_IDLE    13
`define BIT_FULL         7
`define BIT_EMPTY        6
`define BIT_ISEL         5
`define BIT_GO           4
`define BIT_LSB_FIRST    3
`define FLD_WIDTH_LSB    8
`define FLD_LEN_LSB      0

// ----------------------------------------------------------------
// reset values and fifo sizing
// ----------------------------------------------------------------
`define FIELD_RST        5'h00
`define TAP_RST          31'h0
`define WORD_RST         32'h0
`define FIFO_DEEP        5'h10
`define FIFO_SHALLOW     5'h08
`define LEN_SHALLOW_MAX  5'h07

`endif

/* crc_gen_pkg.sv */
`default_nettype none
package crc_gen_pkg;
    typedef logic [7:0]  bus_addr_t;
    typedef logic [31:0] bus_data_t;
    // engine states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } engine_state_t;
endpackage
`default_nettype wire

/* crc_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface crc_fifo_if #(parameter int WIDTH = 32, parameter int CW = 5);
    logic             push;
    logic [WIDTH-1:0] push_data;
    logic             pop;
    logic [WIDTH-1:0] pop_data;
    logic             clear;
    logic [CW-1:0]    cap;
    logic [CW-1:0]    count;
    logic             full;
    logic             empty;
    modport store (input push, push_data, pop, clear, cap,
                   output pop_data, count, full, empty);
    modport user  (output push, push_data, pop, clear, cap,
                   input pop_data, count, full, empty);
endinterface
`default_nettype wire

/* crc_word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module crc_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // fifo port
    crc_fifo_if.store port
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [4:0]       count;
    logic             do_push;
    logic             do_pop;

    // accepted moves; full limit follows the live capacity
    assign do_push       = port.push & ~port.full;
    assign do_pop        = port.pop & ~port.empty;
    assign port.count    = count;
    assign port.full     = (count >= port.cap);
    assign port.empty    = (count == 5'h00);
    assign port.pop_data = mem[rd_ptr];

    // storage write
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr] <= port.push_data;
        end
    end

    // pointers and count, popped in write order
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= 5'h00;
        end else if (port.clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= 5'h00;
        end else begin
            if (do_push) wr_ptr <= wr_ptr + PW'(1);
            if (do_pop) rd_ptr <= rd_ptr + PW'(1);
            count <= count + {4'h0, do_push} - {4'h0, do_pop};
        end
    end

    // a full fifo refuses pushes
    AST_FULL_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
        (port.full && port.push && !port.pop && !port.clear)
        |=> (count == $past(count)))
        else $error("push accepted while fifo full");
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crc_gen_params.svh"
module tb;
    import crc_gen_pkg::*;
    // ----------------------------------------------------------------
    // stimulus signals and counters
    // ----------------------------------------------------------------
    logic      mclk       = 1'b0;
    logic      rst_n      = 1'b0;
    logic      idle_mode  = 1'b0;
    bus_addr_t addr       = 8'h00;
    bus_data_t wdata      = 32'h0;
    logic      wr_en      = 1'b0;
    logic      rd_en      = 1'b0;
    bus_data_t rdata;
    logic      irq;
    int        num_errors = 0;
    int        n_checks   = 0;
    localparam bus_data_t EN   = 32'h1 << `BIT_ENABLE;
    localparam bus_data_t SIDL = 32'h1 << `BIT_STOP_IDLE;
    localparam bus_data_t ISEL = 32'h1 << `BIT_ISEL;
    localparam bus_data_t GO   = 32'h1 << `BIT_GO;
    localparam bus_data_t LSB  = 32'h1 << `BIT_LSB_FIRST;

    // clock generator, 100 MHz
    always #5 mclk = ~mclk;

    programmable_crc_generator #(.DEPTH(16)) i_dut (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .idle_mode (idle_mode),
        .addr      (addr),
        .wdata     (wdata),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .rdata     (rdata),
        .irq       (irq)
    );

    // ----------------------------------------------------------------
    // bus cycles, compares and closing report
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input bus_data_t exp,
                       input bus_data_t got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    task automatic wr(input bus_addr_t a, input bus_data_t d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input string name, input bus_addr_t a,
                        input bus_data_t exp);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    // bounded wait for the interrupt line
    task automatic wait_irq(input int lim, output int cyc);
        cyc = 0;
        while (irq !== 1'b1 && cyc < lim) begin
            @(posedge mclk);
            #1 cyc++;
        end
        if (irq !== 1'b1) begin
            $display("Error irq expected 1 seen %b", irq);
            num_errors++;
            summarize();
        end
    endtask

    // bit-serial reference of the shift engine
    function automatic bus_data_t model(input bus_data_t r0,
        input bus_data_t d, input int w, input int n,
        input bus_data_t tp, input logic lsb);
        bus_data_t r;
        logic      fb;
        r = r0;
        for (int k = 0; k < w; k++) begin
            fb = (lsb ? d[k] : d[w-1-k]) ^ r[n-1];
            for (int i = n - 1; i > 0; i--) begin
                r[i] = r[i-1] ^ (fb & tp[i]);
            end
            r[0] = fb;
        end
        return r & (32'hFFFF_FFFF >> (32 - n));
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic reg_check();
        #1 chk("irq after reset", 32'h0, {31'h0, irq});
        rchk("ctrl one reset", `OFS_CTRL_ONE, 32'h0000_0040);
        rchk("ctrl two reset", `OFS_CTRL_TWO, 32'h0);
        rchk("tap high reset", `OFS_TAP_HIGH, 32'h0);
        rchk("tap low reset", `OFS_TAP_LOW, 32'h0);
        rchk("result reset", `OFS_RESULT, 32'h0);
        wr(`OFS_CTRL_TWO, 32'hFFFF_FFFF);
        rchk("ctrl two mask", `OFS_CTRL_TWO, 32'h0000_1F1F);
        wr(`OFS_TAP_LOW, 32'hFFFF_FFFF);
        rchk("tap low mask", `OFS_TAP_LOW, 32'h0000_FFFE);
        wr(`OFS_TAP_HIGH, 32'hFFFF_FFFF);
        rchk("tap high mask", `OFS_TAP_HIGH, 32'h0000_FFFF);
        wr(`OFS_CTRL_ONE, 32'hFFFF_FFFF);
        rchk("ctrl one mask", `OFS_CTRL_ONE, 32'h0000_A078);
        wr(`OFS_CTRL_ONE, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rchk("unmapped read", 8'h20, 32'h0);
        rchk("data in read", `OFS_DATA_IN, 32'h0);
    endtask

    task automatic fifo_fill();
        wr(`OFS_CTRL_ONE, EN);
        wr(`OFS_CTRL_TWO, 32'h0000_000F);
        for (int i = 0; i < 9; i++) wr(`OFS_DATA_IN, i);
        rchk("full at 8", `OFS_CTRL_ONE, 32'h0000_8880);
        wr(`OFS_CTRL_TWO, 32'h0000_0007);
        rchk("depth 16", `OFS_CTRL_ONE, 32'h0000_8800);
        for (int i = 0; i < 9; i++) wr(`OFS_DATA_IN, i);
        rchk("full at 16", `OFS_CTRL_ONE, 32'h0000_9080);
        wr(`OFS_CTRL_ONE, 32'h0);
        wr(`OFS_DATA_IN, 32'h1);
        rchk("disable clears", `OFS_CTRL_ONE, 32'h0000_0040);
        rchk("tap kept", `OFS_TAP_HIGH, 32'h0000_FFFF);
        rchk("ctrl two kept", `OFS_CTRL_TWO, 32'h0000_0007);
    endtask

    task automatic run_crc(input logic [4:0] lf, input logic [4:0] wf,
        input bus_data_t th, input bus_data_t tl, input logic lsb,
        input bus_data_t d0, input bus_data_t d1, input int nw);
        bus_data_t exp;
        bus_data_t m;
        bus_data_t c1;
        int        cyc;
        m  = 32'hFFFF_FFFF >> (5'h1F - wf);
        c1 = EN | (lsb ? LSB : 32'h0);
        wr(`OFS_CTRL_ONE, c1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_CTRL_TWO, {19'h0, wf, 3'h0, lf});
        wr(`OFS_TAP_HIGH, th);
        wr(`OFS_TAP_LOW, tl);
        wr(`OFS_RESULT, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_DATA_IN, d0);
        if (nw > 1) wr(`OFS_DATA_IN, d1);
        wr(`OFS_CTRL_ONE, c1 | GO);
        wait_irq(400, cyc);
        exp = model(32'h0, d0 & m, int'(wf) + 1, int'(lf) + 1,
                    {th[15:0], tl[15:0]}, lsb);
        if (nw > 1) exp = model(exp, d1 & m, int'(wf) + 1, int'(lf) + 1,
                                {th[15:0], tl[15:0]}, lsb);
        chk("irq after shift", 32'h1,
            {31'h0, cyc >= nw * (int'(wf) + 1)});
        rchk("result", `OFS_RESULT, exp);
        rchk("status set", `OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        @(posedge mclk);
        #1 chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`OFS_CTRL_ONE, c1);
    endtask

    task automatic isel_check();
        int cyc;
        wr(`OFS_CTRL_TWO, 32'h0000_1F0F);
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_CTRL_ONE, EN | ISEL | GO);
        wr(`OFS_DATA_IN, 32'h0BAD_F00D);
        wait_irq(6, cyc);
        wr(`OFS_IRQ_STATUS, 32'h1);
        repeat (40) @(posedge mclk);
        rchk("no done event", `OFS_IRQ_STATUS, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h0);
        wr(`OFS_DATA_IN, 32'h1);
        repeat (40) @(posedge mclk);
        #1 chk("masked irq", 32'h0, {31'h0, irq});
        rchk("status masked", `OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        #1 chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_CTRL_ONE, EN);
    endtask

    task automatic idle_and_go();
        int cyc;
        wr(`OFS_CTRL_TWO, 32'h0000_0707);
        wr(`OFS_CTRL_ONE, EN);
        wr(`OFS_DATA_IN, 32'h5A);
        repeat (20) @(posedge mclk);
        rchk("held go clear", `OFS_CTRL_ONE, 32'h0000_8100);
        idle_mode <= 1'b1;
        wr(`OFS_CTRL_ONE, EN | SIDL | GO);
        repeat (20) @(posedge mclk);
        rchk("frozen idle", `OFS_CTRL_ONE, 32'h0000_A110);
        idle_mode <= 1'b0;
        wait_irq(40, cyc);
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_CTRL_ONE, EN | GO);
        idle_mode <= 1'b1;
        wr(`OFS_DATA_IN, 32'hA5);
        wait_irq(40, cyc);
        idle_mode <= 1'b0;
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_CTRL_ONE, EN);
        wr(`OFS_RESULT, 32'hFFFF_FFFF);
        rchk("result seed", `OFS_RESULT, 32'h0000_00FF);
        wr(`OFS_CTRL_ONE, 32'h0);
        rchk("result cleared", `OFS_RESULT, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        reg_check();
        fifo_fill();
        run_crc(5'h0F, 5'h07, 32'h0, 32'h1020, 1'b0,
                32'hA5, 32'h0, 1);
        run_crc(5'h0F, 5'h07, 32'h0, 32'h1020, 1'b1,
                32'hA5, 32'h0, 1);
        run_crc(5'h1F, 5'h1F, 32'h04C1, 32'h1DB6, 1'b0,
                32'hDEAD_BEEF, 32'h0, 1);
        run_crc(5'h04, 5'h0F, 32'h0, 32'h0015, 1'b0,
                32'h1234, 32'h0, 1);
        run_crc(5'h00, 5'h03, 32'h0, 32'h0, 1'b1, 32'h5, 32'h0, 1);
        run_crc(5'h0F, 5'h07, 32'h0, 32'h1020, 1'b1,
                32'h31, 32'hFFC2, 2);
        isel_check();
        idle_and_go();
        summarize();
    end
endmodule
`default_nettype wire
